//--- hdl/setpoint_group_selector.sv
// Setpoint group selector: picks the active and edit protection groups,
// drives group indicators, aux relay selection and a change event.
// Assumes all pin-level status inputs are asynchronous; settings are
// stable levels from the same clock domain.
//
// Notes on behaviour
// RULE_01: Four setting groups exist; exactly one is active at a time.
// RULE_02: Active group indicator is driven steadily on.
// RULE_03: Edit group indicator flashes when it differs from active group.
// RULE_04: Same active and edit group shows steady on.
// RULE_05: Edit group comes only from the stored setting.
// RULE_06: Group 1 is active by default unless another is requested.
// RULE_07: Active group requested by setting or per-group logic inputs.
// RULE_08: Highest requested group wins; withdrawal falls to next highest.
// RULE_09: A change away from group 1 logs an event.
// RULE_10: Enabled overcurrent pickup inhibit blocks group changes.
// RULE_11: Any element not disabled counts as able to pick up.
// RULE_12: Enabled open-breaker inhibit blocks changes; disabled by default.
// RULE_13: Enabled overvoltage pickup inhibit blocks changes.
// RULE_14: Enabled bus or line undervoltage inhibit blocks changes.
// RULE_15: Enabled underfrequency inhibit blocks changes.
// RULE_16: Edit setting offers groups 1 to 4 or follow, default follow.
// RULE_17: Each group holds its own aux relay 3 to 7 selection.
// RULE_18: Hold group while inhibited, apply request once inhibits clear.
`timescale 1ns/100ps
module setpoint_group_selector (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Stored settings (same clock domain)
  input  wire logic [1:0]  active_setting_i,
  input  wire logic [2:0]  edit_setting_i,
  input  wire logic        open_breaker_block_i,
  input  wire logic        overcurrent_change_block_i,
  input  wire logic        overvoltage_change_block_i,
  input  wire logic        undervoltage_change_block_i,
  input  wire logic        underfrequency_change_block_i,
  input  wire logic [4:0]  aux_sel_g1_i,
  input  wire logic [4:0]  aux_sel_g2_i,
  input  wire logic [4:0]  aux_sel_g3_i,
  input  wire logic [4:0]  aux_sel_g4_i,
  // Asynchronous pin-level inputs
  input  wire logic [3:0]  group_req_i,
  input  wire logic        breaker_open_i,
  input  wire logic        oc_pickup_i,
  input  wire logic        ov_pickup_i,
  input  wire logic        uv_pickup_i,
  input  wire logic        uf_pickup_i,
  // Results
  output logic [1:0]       active_group_o,
  output logic [1:0]       edit_group_o,
  output logic [3:0]       group_led_o,
  output logic [4:0]       aux_sel_o,
  output logic             group_event_o,
  output logic             inhibited_o
);

  localparam int NSYNC = 9;

  // Two-stage synchronisers for all pin-level inputs
  logic [NSYNC-1:0] pins_async;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;

  assign pins_async = {group_req_i, breaker_open_i, oc_pickup_i,
                       ov_pickup_i, uv_pickup_i, uf_pickup_i};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_async;
      sync2_reg <= sync1_reg;
    end
  end

  logic [3:0] req_s;
  logic       brk_open_s;
  logic       oc_s;
  logic       ov_s;
  logic       uv_s;
  logic       uf_s;

  assign req_s      = sync2_reg[8:5];
  assign brk_open_s = sync2_reg[4];
  assign oc_s       = sync2_reg[3];
  assign ov_s       = sync2_reg[2];
  assign uv_s       = sync2_reg[1];
  assign uf_s       = sync2_reg[0];

  // Merge setting and input requests; one bit per group 1 to 4, several may be set
  logic [3:0] req_all;
  logic [3:0] set_onehot;

  assign set_onehot = 4'h1 << active_setting_i;               // [RULE_07]
  assign req_all    = req_s | set_onehot;                     // [RULE_07]

  // Highest-numbered request wins; setting always gives one request
  logic [1:0] requested;

  always_comb begin
    requested = group_sel_pkg::DEFAULT_GROUP;                 // [RULE_06]
    for (int i = 0; i < group_sel_pkg::NUM_GROUPS; i++) begin
      if (req_all[i]) begin
        requested = 2'(i);                                    // [RULE_08]
      end
    end
  end

  // Pickup inputs are ORs of every element whose function is not
  // disabled, so non-tripping elements inhibit too.
  logic inhibit;

  assign inhibit = (open_breaker_block_i        & brk_open_s)  // [RULE_12]
                 | (overcurrent_change_block_i  & oc_s)  // [RULE_10] [RULE_11]
                 | (overvoltage_change_block_i  & ov_s)        // [RULE_13]
                 | (undervoltage_change_block_i & uv_s)        // [RULE_14]
                 | (underfrequency_change_block_i & uf_s);     // [RULE_15]

  // Active group register; holds while any enabled inhibit is true
  logic [1:0] active_reg;
  logic [1:0] active_next;

  assign active_next = inhibit ? active_reg : requested;      // [RULE_18]

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      active_reg <= group_sel_pkg::DEFAULT_GROUP;             // [RULE_06]
    end else begin
      active_reg <= active_next;                              // [RULE_01]
    end
  end

  // Edit group comes from the setting only; follow tracks the active group
  logic [1:0] edit_next;

  always_comb begin
    if (edit_setting_i >= group_sel_pkg::EDIT_FOLLOW) begin
      edit_next = active_next;                                // [RULE_16]
    end else begin
      edit_next = edit_setting_i[1:0];                        // [RULE_05]
    end
  end

  // Indicator flash source
  logic flash;

  flash_gen u_flash_gen (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .flash_o (flash)
  );

  // Indicator pattern per group; steady wins when edit equals active
  logic [3:0] led_next;

  generate
    for (genvar g = 0; g < group_sel_pkg::NUM_GROUPS; g++) begin : g_led
      always_comb begin
        if (active_next == 2'(g)) begin
          led_next[g] = 1'b1;  // [RULE_02] [RULE_04]
        end else if (edit_next == 2'(g)) begin
          led_next[g] = flash;                                // [RULE_03]
        end else begin
          led_next[g] = 1'b0;
        end
      end
    end
  endgenerate

  // Per-group aux relay selection, chosen by the active group
  logic [4:0] aux_next;

  always_comb begin
    case (active_next)
      2'h0:    aux_next = aux_sel_g1_i;                       // [RULE_17]
      2'h1:    aux_next = aux_sel_g2_i;                       // [RULE_17]
      2'h2:    aux_next = aux_sel_g3_i;                       // [RULE_17]
      2'h3:    aux_next = aux_sel_g4_i;                       // [RULE_17]
      default: aux_next = aux_sel_g1_i;
    endcase
  end

  // Registered outputs, all aligned with the active group register
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      active_group_o <= group_sel_pkg::DEFAULT_GROUP;
      edit_group_o   <= group_sel_pkg::DEFAULT_GROUP;
      group_led_o    <= group_sel_pkg::LED_RESET;
      aux_sel_o      <= group_sel_pkg::AUX_RESET;
      inhibited_o    <= 1'b0;
    end else begin
      active_group_o <= active_next;
      edit_group_o   <= edit_next;
      group_led_o    <= led_next;
      aux_sel_o      <= aux_next;
      inhibited_o    <= inhibit;
    end
  end

  // Departure from group 1, judged on the edge that moves the group
  logic leave_default;

  assign leave_default = (active_reg == group_sel_pkg::DEFAULT_GROUP) &&
                         (active_next != group_sel_pkg::DEFAULT_GROUP);

  // Event pulse on a change away from group 1; a change back to group 1
  // is not logged, so the recorder sees only departures.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      group_event_o <= 1'b0;
    end else begin
      group_event_o <= leave_default;                           // [RULE_09]
    end
  end

  // Assertions
  sequence s_change_away;
    (active_reg == 2'h0) ##1 (active_reg != 2'h0);
  endsequence

  a_event_on_leave: assert property (  // [RULE_09]
    @(posedge clock_i) disable iff (rst_i)
    s_change_away |-> group_event_o)
    else $error("Leaving group 1 gave no event pulse");

  a_event_cause: assert property (  // [RULE_09]
    @(posedge clock_i) disable iff (rst_i)
    group_event_o |-> ($past(active_reg) == 2'h0) && (active_reg != 2'h0))
    else $error("Event pulse without leaving group 1");

  a_hold_inhibit: assert property (  // [RULE_18]
    @(posedge clock_i) disable iff (rst_i)
    inhibit |=> $stable(active_reg))
    else $error("Active group changed while inhibited");

  a_apply_free: assert property (  // [RULE_08]
    @(posedge clock_i) disable iff (rst_i)
    !inhibit |=> (active_reg == $past(requested)))
    else $error("Request not applied when free");

  a_highest_wins: assert property (  // [RULE_08]
    @(posedge clock_i) disable iff (rst_i)
    !inhibit && req_all[3] |=> (active_group_o == 2'h3))
    else $error("Group 4 request did not win");

  a_brk_block: assert property (  // [RULE_12]
    @(posedge clock_i) disable iff (rst_i)
    open_breaker_block_i && brk_open_s |=> $stable(active_reg))
    else $error("Group changed with breaker open and inhibit on");

  a_oc_block: assert property (  // [RULE_10]
    @(posedge clock_i) disable iff (rst_i)
    overcurrent_change_block_i && oc_s |=> $stable(active_reg))
    else $error("Group changed during overcurrent pickup");

  a_active_led: assert property (  // [RULE_02]
    @(posedge clock_i) disable iff (rst_i)
    group_led_o[active_group_o])
    else $error("Active group indicator not on");

  a_one_steady: assert property (  // [RULE_01]
    @(posedge clock_i) disable iff (rst_i)
    (edit_group_o == active_group_o) |-> $onehot(group_led_o))
    else $error("Indicators wrong when edit equals active");

  a_follow_edit: assert property (  // [RULE_16]
    @(posedge clock_i) disable iff (rst_i)
    edit_setting_i[2] |=> (edit_group_o == active_group_o))
    else $error("Edit group not following active group");

  a_edit_fixed: assert property (  // [RULE_05]
    @(posedge clock_i) disable iff (rst_i)
    !edit_setting_i[2] |=> (edit_group_o == $past(edit_setting_i[1:0])))
    else $error("Edit group not taken from setting");

  // Helper sequences for the multi-step checks below
  sequence s_stay_default;
    (active_reg == 2'h0) ##1 (active_reg == 2'h0);
  endsequence

  sequence s_drop_top;
    (!inhibit && req_all[3]) ##1 (!inhibit && (req_all[3:2] == 2'b01));
  endsequence

  a_no_event_stay: assert property (  // [RULE_09]
    @(posedge clock_i) disable iff (rst_i)
    s_stay_default |-> !group_event_o)
    else $error("Event pulse while staying in group 1");

  a_event_one_cycle: assert property (  // [RULE_09]
    @(posedge clock_i) disable iff (rst_i)
    group_event_o |=> !group_event_o)
    else $error("Event pulse longer than one cycle");

  a_fall_back: assert property (  // [RULE_08]
    @(posedge clock_i) disable iff (rst_i)
    s_drop_top |=> (active_reg == 2'h2))
    else $error("Withdrawn group 4 did not fall back to group 3");

  a_default_idle: assert property (  // [RULE_06]
    @(posedge clock_i) disable iff (rst_i)
    !inhibit && (req_all == 4'h1) |=> (active_reg == 2'h0))
    else $error("Group 1 not used without other requests");

  a_ov_block: assert property (  // [RULE_13]
    @(posedge clock_i) disable iff (rst_i)
    overvoltage_change_block_i && ov_s |=> $stable(active_reg))
    else $error("Group changed during overvoltage pickup");

  a_uv_block: assert property (  // [RULE_14]
    @(posedge clock_i) disable iff (rst_i)
    undervoltage_change_block_i && uv_s |=> $stable(active_reg))
    else $error("Group changed during undervoltage pickup");

  a_uf_block: assert property (  // [RULE_15]
    @(posedge clock_i) disable iff (rst_i)
    underfrequency_change_block_i && uf_s |=> $stable(active_reg))
    else $error("Group changed during underfrequency pickup");

  a_hold_output: assert property (  // [RULE_18]
    @(posedge clock_i) disable iff (rst_i)
    inhibited_o |-> $stable(active_group_o))
    else $error("Active group output moved while inhibited");

  a_edit_flash: assert property (  // [RULE_03]
    @(posedge clock_i) disable iff (rst_i)
    (edit_group_o != active_group_o) |->
      (group_led_o[edit_group_o] == $past(flash)))
    else $error("Edit group indicator not following flash phase");

  a_led_pattern: assert property (  // [RULE_04]
    @(posedge clock_i) disable iff (rst_i)
    (group_led_o & ~((4'h1 << active_group_o) |
                     (4'h1 << edit_group_o))) == 4'h0)
    else $error("Indicator lit for a group neither active nor edited");

  a_aux_group_one: assert property (  // [RULE_17]
    @(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) && (active_group_o == 2'h0) |->
      (aux_sel_o == $past(aux_sel_g1_i)))
    else $error("Aux selection not taken from group 1");

  a_aux_group_four: assert property (  // [RULE_17]
    @(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) && (active_group_o == 2'h3) |->
      (aux_sel_o == $past(aux_sel_g4_i)))
    else $error("Aux selection not taken from group 4");

endmodule : setpoint_group_selector

//--- hdl/group_sel_pkg.sv
// Constants shared by the setpoint group selector and its flasher.
// Assumes a single 10 MHz clock and an asynchronous active-high reset.
package group_sel_pkg;
  localparam int          NUM_GROUPS     = 4;
  localparam int          GROUP_W        = 2;
  localparam int          AUX_W          = 5;        // Aux relays 3 to 7
  localparam logic [1:0]  DEFAULT_GROUP  = 2'h0;     // Group 1
  localparam logic [2:0]  EDIT_FOLLOW    = 3'h4;     // Follow active group
  localparam logic [3:0]  LED_RESET      = 4'h1;
  localparam logic [4:0]  AUX_RESET      = 5'h00;
  // Flash half period of the edit group indicator
  localparam int          CLOCK_HZ       = 10_000_000;
  localparam int          FLASH_HALF_MS  = 250;
  localparam int          FLASH_HALF_CYC = CLOCK_HZ / 1000 * FLASH_HALF_MS;
  localparam int          FLASH_CNT_W    = 22;
endpackage : group_sel_pkg

//--- hdl/flash_gen.sv
// Free-running square wave for the flashing edit-group indicator.
// Assumes the half period fits in the counter width.
`timescale 1ns/100ps
module flash_gen #(
  parameter int HALF_CYC = group_sel_pkg::FLASH_HALF_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  output logic      flash_o
);
  logic [group_sel_pkg::FLASH_CNT_W-1:0] cnt_reg;

  // Toggle the phase every half period
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      flash_o <= 1'b0;
    end else if (cnt_reg ==
                 group_sel_pkg::FLASH_CNT_W'(HALF_CYC - 1)) begin
      cnt_reg <= '0;
      flash_o <= ~flash_o;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : flash_gen

//--- verif/far_side_model.sv
// Far side: logic input contacts, element pickups and breaker status.
// Assumes the bench commands levels just after a clock edge.
`timescale 1ns/100ps
module far_side_model (
  input  wire logic [3:0] req_i,
  input  wire logic [4:0] cond_i,
  input  wire logic [3:0] elem_on_i,
  output logic      [3:0] group_req_o,
  output logic            breaker_open_o,
  output logic            oc_pickup_o,
  output logic            ov_pickup_o,
  output logic            uv_pickup_o,
  output logic            uf_pickup_o
);
  // A pickup shows only for elements whose function is not disabled
  assign group_req_o    = req_i;
  assign breaker_open_o = cond_i[0];
  assign oc_pickup_o    = cond_i[1] & elem_on_i[0];
  assign ov_pickup_o    = cond_i[2] & elem_on_i[1];
  assign uv_pickup_o    = cond_i[3] & elem_on_i[2];
  assign uf_pickup_o    = cond_i[4] & elem_on_i[3];
endmodule : far_side_model

//--- verif/tb_top.sv
// Self-checking bench for the setpoint group selector.
// Assumes pin inputs settle within four edges and settings within one.
`timescale 1ns/100ps
module tb_top;
  logic       clock_i  = 1'b0;
  logic       rst_i    = 1'b1;
  logic [1:0] act_set  = 2'h0;
  logic [2:0] edit_set = 3'h4;
  logic [4:0] blk_en   = 5'h00;
  logic [4:0] cond     = 5'h00;
  logic [3:0] req      = 4'h0;
  logic [3:0] elem_on  = 4'hF;
  logic [3:0] grp_req;
  logic       brk, oc, ov, uv, uf;
  logic [1:0] active_group_o, edit_group_o;
  logic [3:0] group_led_o;
  logic [4:0] aux_sel_o;
  logic       group_event_o, inhibited_o;
  int         errors = 0;
  int         comparisons = 0;
  int         events;

  always #50 clock_i = ~clock_i;

  far_side_model u_far_side_model (.req_i(req), .cond_i(cond),
    .elem_on_i(elem_on), .group_req_o(grp_req), .breaker_open_o(brk),
    .oc_pickup_o(oc), .ov_pickup_o(ov), .uv_pickup_o(uv),
    .uf_pickup_o(uf));

  setpoint_group_selector u_setpoint_group_selector (
    .clock_i(clock_i), .rst_i(rst_i), .active_setting_i(act_set),
    .edit_setting_i(edit_set), .open_breaker_block_i(blk_en[0]),
    .overcurrent_change_block_i(blk_en[1]),
    .overvoltage_change_block_i(blk_en[2]),
    .undervoltage_change_block_i(blk_en[3]),
    .underfrequency_change_block_i(blk_en[4]),
    .aux_sel_g1_i(5'h11), .aux_sel_g2_i(5'h12), .aux_sel_g3_i(5'h14),
    .aux_sel_g4_i(5'h18), .group_req_i(grp_req), .breaker_open_i(brk),
    .oc_pickup_i(oc), .ov_pickup_i(ov), .uv_pickup_i(uv),
    .uf_pickup_i(uf), .active_group_o(active_group_o),
    .edit_group_o(edit_group_o), .group_led_o(group_led_o),
    .aux_sel_o(aux_sel_o), .group_event_o(group_event_o),
    .inhibited_o(inhibited_o));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // Fixed wait, counting one-cycle change pulses as they pass
  task automatic run(input int n);
    events = 0;
    repeat (n) begin
      @(posedge clock_i);
      #1;
      if (group_event_o === 1'b1) events++;
    end
  endtask : run

  // Apply a request and setting, then judge group, relays and event
  task automatic step(input logic [3:0] r, input logic [1:0] s,
                      input logic [1:0] ea, input int ee);
    @(posedge clock_i);
    req     <= r;
    act_set <= s;
    run(6);
    check(8'(active_group_o), 8'(ea));
    check(8'(aux_sel_o), 8'(5'h10 | (5'h01 << ea)));
    check(8'(events), 8'(ee));
    check(8'(group_led_o), 8'(4'h1 << ea));
  endtask : step

  task automatic t_priority;
    step(4'hE, 2'h0, 2'h3, 1);
    step(4'h6, 2'h0, 2'h2, 0);
    step(4'h2, 2'h2, 2'h2, 0);
    step(4'h1, 2'h1, 2'h1, 0);
    step(4'h0, 2'h0, 2'h0, 0);
  endtask : t_priority

  // Each inhibit holds the group, then releases the pending request
  task automatic t_inhibit;
    for (int k = 0; k < 5; k++) begin
      @(posedge clock_i);
      blk_en <= 5'h01 << k;
      cond   <= 5'h01 << k;
      step(4'h4, 2'h0, 2'h0, 0);
      check(8'(inhibited_o), 8'h01);
      @(posedge clock_i);
      cond <= 5'h00;
      run(6);
      check(8'(active_group_o), 8'h02);
      step(4'h0, 2'h0, 2'h0, 0);
    end
    // Disabled inhibits leave pickups without effect
    @(posedge clock_i);
    blk_en <= 5'h00;
    cond   <= 5'h1F;
    step(4'h8, 2'h0, 2'h3, 1);
    check(8'(inhibited_o), 8'h00);
    // Pickups of disabled elements never reach the inhibit
    @(posedge clock_i);
    elem_on <= 4'h0;
    run(3);
    @(posedge clock_i);
    blk_en <= 5'h1E;
    step(4'h2, 2'h0, 2'h1, 0);
    check(8'(inhibited_o), 8'h00);
    step(4'h8, 2'h0, 2'h3, 0);
  endtask : t_inhibit

  // Flash phase is not judged: its half period far exceeds the run
  task automatic t_edit;
    for (int e = 0; e < 8; e++) begin
      @(posedge clock_i);
      edit_set <= 3'(e);
      run(2);
      if (e < 3) begin
        check(8'(edit_group_o), 8'(e));
        check(8'(group_led_o & ~(4'h1 << e)), 8'h08);
      end else if (e == 3) begin
        check(8'(edit_group_o), 8'h03);
        check(8'(group_led_o), 8'h08);
      end else begin
        check(8'(edit_group_o), 8'h03);
        check(8'(group_led_o), 8'h08);
      end
    end
  endtask : t_edit

  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    check(8'(group_led_o), 8'h01);
    check(8'({active_group_o, edit_group_o, aux_sel_o}), 8'h00);
    check(8'({group_event_o, inhibited_o}), 8'h00);
    @(posedge clock_i);
    rst_i <= 1'b0;
    run(2);
    check(8'(edit_group_o), 8'h00);
    t_priority();
    t_inhibit();
    t_edit();
    wrap_up();
  end
endmodule : tb_top
